// ---- design/iobtr_dc_match.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Delayed completion slot comparator.
// ****************************************************************
module iobtr_dc_match (
  iobtr_match_if.matcher mif
);
  import iobtr_pkg::*;

  // Address mask: relaxed mode drops the top and bottom address bits.
  wire [63:0] addrMask = mif.relaxed ? RELAX_MASK : {64{1'b1}};
  // Byte enables never enter the compare; these reads are prefetchable.
  wire addrEq = ((mif.reqAddr ^ mif.slotAddr) & addrMask) == 64'h0000000000000000;
  wire wideEq = mif.relaxed || (mif.reqWide == mif.slotWide);
  wire cmdEq = mif.relaxed || (mif.reqCmd == mif.slotCmd);
  wire parEq = mif.reqPar == mif.slotPar;
  // Master identity is compared in both modes, which keeps two cards apart.
  wire midEq = mif.reqMaster == mif.slotMaster;

  assign mif.hit = addrEq && wideEq && cmdEq && parEq && midEq;

endmodule : iobtr_dc_match
`default_nettype wire

// ---- design/iobtr_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Retried read matches on address, width, command, parity, master.
// - Delayed slot only for reads; retry, then data.
// - Strict match default; relaxed drops bits, width, command.
// - Bus mode chosen only at bus reset.
// - Any transfer length accepted in split mode.
// - Split mode carries processor and message accesses; config is unclaimed.
// - Address parity checked only on decoding phases.
// - Data parity ignored on own read split reply.
// - Card parity error ignored while driving split reply.
// - Aborted split completion raises system error.
// - Split mode claims reads; replies split or retry.
// - Split mode claims writes with four reply kinds.
// - Accept own read completions and peer writes.
// - Conventional mode claims reads with delayed replies.
// - Conventional writes get retry or immediate; accept dual.
// - Graphics requests enter pipeline; flush like read.
// - Fence updates ordering state only.
module iobtr_top (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic busClk,
  input wire logic busReset_n,
  input wire logic relaxedMatch,
  input wire logic splitCapStrap,
  input wire logic agpStrap,
  input wire logic cycValid,
  input wire logic [iobtr_pkg::ADDR_W-1:0] cycAddr,
  input wire logic [3:0] cycCmd,
  input wire logic cycWide,
  input wire logic cycPar,
  input wire logic [iobtr_pkg::MID_W-1:0] cycMaster,
  input wire logic cycOwnCompletion,
  input wire logic cycSinglePhase,
  input wire logic writeFull,
  input wire logic splitFull,
  input wire logic phaseValid,
  input wire logic [31:0] phaseAd,
  input wire logic [3:0] phaseCbe,
  input wire logic phasePar,
  input wire logic phaseRedundant,
  input wire logic agpValid,
  input wire logic [3:0] agpCmd,
  input wire logic dataParErr,
  input wire logic ownReadSplitted,
  input wire logic perrIn,
  input wire logic splitCompAbort,
  input wire logic dmaDataDone,
  output logic claim,
  output iobtr_pkg::iobtr_reply_t replyCode,
  output logic splitMode,
  output logic agpMode,
  output logic addrParErr,
  output logic dataParErrSeen,
  output logic perrSeen,
  output logic serrOut,
  output logic pipeEnq,
  output logic [iobtr_pkg::FENCE_W-1:0] fenceCount,
  output logic dmaReadStart,
  output logic [iobtr_pkg::ADDR_W-1:0] dmaReadAddr
);
  import iobtr_pkg::*;

  // ****************************************************************
  // Reset synchronisers.
  // ****************************************************************
  logic [1:0] coreRstPipe; // Core reset release pipeline.
  logic [1:0] busRstPipe; // Bus reset release pipeline.
  wire coreRst_n = coreRstPipe[1];
  wire busRst_n = busRstPipe[1];

  // Core reset is released through two flops.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      coreRstPipe <= 2'h0;
    end else begin
      coreRstPipe <= {coreRstPipe[0], 1'b1};
    end
  end

  // Bus reset is released the same way on the bus clock.
  always_ff @(posedge busClk or negedge busReset_n) begin
    if (!busReset_n) begin
      busRstPipe <= 2'h0;
    end else begin
      busRstPipe <= {busRstPipe[0], 1'b1};
    end
  end

  // ****************************************************************
  // Bus side input crossings.
  // ****************************************************************
  logic [3:0] bsA; // First stage, read only by the second.
  logic [3:0] bsB; // Second stage.
  logic [3:0] bsC; // Third stage.
  logic [3:0] bsF; // Filtered value, moves only when stages agree.
  logic doneTgl; // Core side toggle for finished reads.
  wire [3:0] bsIn = {doneTgl, relaxedMatch, agpStrap, splitCapStrap};
  wire [3:0] bsAgree = ~(bsB ^ bsC);
  wire relaxedS = bsF[2];
  wire doneTglS = bsF[3];

  // Three stage sync; a change counts once stages two and three agree.
  always_ff @(posedge busClk or negedge busRst_n) begin
    if (!busRst_n) begin
      bsA <= 4'h0;
      bsB <= 4'h0;
      bsC <= 4'h0;
      bsF <= 4'h0;
    end else begin
      bsA <= bsIn;
      bsB <= bsA;
      bsC <= bsB;
      bsF <= (bsAgree & bsC) | (~bsAgree & bsF);
    end
  end

  // ****************************************************************
  // Mode capture at bus reset.
  // ****************************************************************
  logic [1:0] settle; // Waits for the strap filter to fill after release.
  logic modeLocked; // Set once the mode is taken; stays until next reset.

  // The mode is only taken right after bus reset, never per cycle.
  always_ff @(posedge busClk or negedge busRst_n) begin
    if (!busRst_n) begin
      settle <= 2'h0;
      modeLocked <= 1'b0;
      splitMode <= 1'b0;
      agpMode <= 1'b0;
    end else if (!modeLocked) begin
      settle <= settle + 2'h1;
      // At this edge the filter is only now loading the straps, so the third
      // stage is read instead; stages two and three already agree here.
      if (settle == 2'h3) begin
        modeLocked <= 1'b1;
        agpMode <= bsC[1];
        splitMode <= bsC[0] && !bsC[1];
      end
    end
  end

  // ****************************************************************
  // Delayed completion slot.
  // ****************************************************************
  iobtr_slot_t slotState; // Slot occupancy.
  logic [63:0] slotAddr; // Captured address, stable while occupied.
  logic slotWide; // Captured wide request state.
  logic [3:0] slotCmd; // Captured command.
  logic slotPar; // Captured address parity.
  logic [2:0] slotMaster; // Captured master identity.
  logic reqTgl; // Toggles once per new read sent to the core.
  logic doneSeen; // Last filtered done toggle value taken.
  iobtr_match_if mif ();

  assign mif.reqAddr = cycAddr;
  assign mif.reqWide = cycWide;
  assign mif.reqCmd = cycCmd;
  assign mif.reqPar = cycPar;
  assign mif.reqMaster = cycMaster;
  assign mif.slotAddr = slotAddr;
  assign mif.slotWide = slotWide;
  assign mif.slotCmd = slotCmd;
  assign mif.slotPar = slotPar;
  assign mif.slotMaster = slotMaster;
  assign mif.relaxed = relaxedS;

  iobtr_dc_match uMatch (
    .mif(mif)
  );

  // ****************************************************************
  // Cycle decode.
  // ****************************************************************
  wire convCycle = cycValid && modeLocked && !splitMode;
  wire splitCycle = cycValid && modeLocked && splitMode;
  wire convRead = convCycle && iobtrIsConvRead(cycCmd);
  wire convWrite = convCycle && (cycCmd == CMD_MEM_WR || cycCmd == CMD_INVAL_BLKWR);
  wire convDac = convCycle && (cycCmd == CMD_DAC);
  wire splitRead = splitCycle && (cycCmd == CMD_MEM_RD || cycCmd == CMD_LINE_BLKRD);
  wire splitWrite = splitCycle && (cycCmd == CMD_MEM_WR || cycCmd == CMD_INVAL_BLKWR);
  wire splitCompl = splitCycle && (cycCmd == CMD_MULT_SPLIT) && cycOwnCompletion;
  wire slotHit = (slotState != SLOT_IDLE) && mif.hit;
  wire slotDeliver = convRead && slotHit && (slotState == SLOT_READY);
  wire slotCapture = convRead && (slotState == SLOT_IDLE);
  wire doneEvent = (doneTglS != doneSeen);
  wire blockAligned = cycAddr[6:0] == BLOCK_OFFSET_ZERO;
  iobtr_reply_t next_reply;

  // Reply selection; cycles not listed are left unclaimed, except a conventional dual cycle.
  always_comb begin
    next_reply = RPL_NONE;
    if (splitRead) begin
      // Any length is taken; short reads simply run less efficiently.
      next_reply = splitFull ? RPL_RETRY : RPL_SPLIT;
    end else if (splitWrite) begin
      // Message interrupts arrive as ordinary memory writes here.
      if (writeFull) begin
        next_reply = RPL_RETRY;
      end else if (cycSinglePhase) begin
        next_reply = RPL_SINGLE_DISC;
      end else if (!blockAligned) begin
        next_reply = RPL_DISC_NEXT;
      end else begin
        next_reply = RPL_DATA_XFER;
      end
    end else if (splitCompl) begin
      next_reply = RPL_DATA_XFER;
    end else if (convRead) begin
      next_reply = slotDeliver ? RPL_DELAYED : RPL_RETRY;
    end else if (convWrite) begin
      next_reply = writeFull ? RPL_RETRY : RPL_IMMEDIATE;
    end else if (agpValid && modeLocked && agpMode && agpCmd != AGP_FENCE) begin
      next_reply = RPL_PIPE;
    end
  end

  // Slot bookkeeping; a done event and a release never meet in one state.
  always_ff @(posedge busClk or negedge busRst_n) begin
    if (!busRst_n) begin
      slotState <= SLOT_IDLE;
      slotAddr <= 64'h0000000000000000;
      slotWide <= 1'b0;
      slotCmd <= 4'h0;
      slotPar <= 1'b0;
      slotMaster <= 3'h0;
      reqTgl <= 1'b0;
      doneSeen <= 1'b0;
    end else begin
      doneSeen <= doneTglS;
      if (slotCapture) begin
        slotState <= SLOT_PENDING;
        slotAddr <= cycAddr;
        slotWide <= cycWide;
        slotCmd <= cycCmd;
        slotPar <= cycPar;
        slotMaster <= cycMaster;
        reqTgl <= ~reqTgl;
      end else if (slotDeliver) begin
        slotState <= SLOT_IDLE;
      end else if (doneEvent && slotState == SLOT_PENDING) begin
        slotState <= SLOT_READY;
      end
    end
  end

  // ****************************************************************
  // Replies, ordering state and error reporting.
  // ****************************************************************
  wire phaseParBad = ^{phaseAd, phaseCbe, phasePar};
  wire driveSplit = (replyCode == RPL_SPLIT);
  wire agpTake = agpValid && modeLocked && agpMode;

  // Registered reply outputs, one cycle after the decode point.
  always_ff @(posedge busClk or negedge busRst_n) begin
    if (!busRst_n) begin
      claim <= 1'b0;
      replyCode <= RPL_NONE;
      pipeEnq <= 1'b0;
      fenceCount <= 4'h0;
    end else begin
      // The address prefix of a dual cycle is taken without its own reply.
      claim <= (next_reply != RPL_NONE) || convDac;
      replyCode <= next_reply;
      // Flush, reads, writes and dual forms all go into the pipeline.
      pipeEnq <= agpTake && agpCmd != AGP_FENCE;
      if (agpTake && agpCmd == AGP_FENCE) begin
        fenceCount <= fenceCount + 4'h1;
      end
    end
  end

  // Error flags; a redundant address phase cannot harm us, so it is skipped.
  always_ff @(posedge busClk or negedge busRst_n) begin
    if (!busRst_n) begin
      addrParErr <= 1'b0;
      dataParErrSeen <= 1'b0;
      perrSeen <= 1'b0;
      serrOut <= 1'b0;
    end else begin
      addrParErr <= phaseValid && !phaseRedundant && phaseParBad;
      dataParErrSeen <= dataParErr && !(splitMode && ownReadSplitted);
      perrSeen <= perrIn && !driveSplit;
      serrOut <= splitMode && splitCompAbort;
    end
  end

  // ****************************************************************
  // Core side of the read request and completion crossing.
  // ****************************************************************
  logic [2:0] csA; // Request toggle sync stages.
  logic reqSeen; // Filtered request toggle.
  logic reqTaken; // Last request toggle acted on.
  wire csAgree = (csA[1] == csA[2]);

  // Request toggle passes three flops; the address is stable while pending.
  always_ff @(posedge core_clk or negedge coreRst_n) begin
    if (!coreRst_n) begin
      csA <= 3'h0;
      reqSeen <= 1'b0;
      reqTaken <= 1'b0;
      dmaReadStart <= 1'b0;
      dmaReadAddr <= 64'h0000000000000000;
      doneTgl <= 1'b0;
    end else begin
      csA <= {csA[1:0], reqTgl};
      if (csAgree) begin
        reqSeen <= csA[2];
      end
      reqTaken <= reqSeen;
      dmaReadStart <= reqSeen != reqTaken;
      if (reqSeen != reqTaken) begin
        dmaReadAddr <= slotAddr;
      end
      if (dmaDataDone) begin
        doneTgl <= ~doneTgl;
      end
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  property p_split_io_unclaimed;
    @(posedge busClk) disable iff (!busRst_n)
      (splitCycle && (cycCmd == CMD_IO_RD || cycCmd == CMD_CFG_WR || cycCmd == CMD_DAC))
      |=> !claim;
  endproperty
  a_split_io_unclaimed: assert property (p_split_io_unclaimed)
    else $error("split mode claimed an excluded command");

  property p_split_read_reply;
    @(posedge busClk) disable iff (!busRst_n)
      splitRead |=> claim && (replyCode == RPL_SPLIT || replyCode == RPL_RETRY);
  endproperty
  a_split_read_reply: assert property (p_split_read_reply)
    else $error("split mode read got a wrong reply");

  property p_conv_capture;
    @(posedge busClk) disable iff (!busRst_n)
      slotCapture |=> replyCode == RPL_RETRY && slotState == SLOT_PENDING && $changed(reqTgl);
  endproperty
  a_conv_capture: assert property (p_conv_capture)
    else $error("new conventional read not retried into the slot");

  property p_release;
    @(posedge busClk) disable iff (!busRst_n)
      replyCode == RPL_DELAYED |-> slotState == SLOT_IDLE && $past(slotState) == SLOT_READY;
  endproperty
  a_release: assert property (p_release)
    else $error("delayed data given without releasing a ready slot");

  property p_redundant_parity;
    @(posedge busClk) disable iff (!busRst_n)
      phaseValid && phaseRedundant |=> !addrParErr;
  endproperty
  a_redundant_parity: assert property (p_redundant_parity)
    else $error("parity flagged on a redundant address phase");

  property p_perr_during_split;
    @(posedge busClk) disable iff (!busRst_n)
      perrIn && driveSplit |=> !perrSeen;
  endproperty
  a_perr_during_split: assert property (p_perr_during_split)
    else $error("card parity error reported while driving split reply");

  property p_abort_serr;
    @(posedge busClk) disable iff (!busRst_n)
      splitMode && splitCompAbort |=> serrOut;
  endproperty
  a_abort_serr: assert property (p_abort_serr)
    else $error("aborted split completion did not raise system error");

  property p_fence;
    @(posedge busClk) disable iff (!busRst_n)
      agpTake && agpCmd == AGP_FENCE |=> !pipeEnq && fenceCount == $past(fenceCount) + 4'h1;
  endproperty
  a_fence: assert property (p_fence)
    else $error("fence moved data or missed the ordering count");

  property p_mode_stable;
    @(posedge busClk) disable iff (!busRst_n)
      modeLocked |=> $stable(splitMode) && $stable(agpMode);
  endproperty
  a_mode_stable: assert property (p_mode_stable)
    else $error("bus mode changed outside bus reset");

  property p_req_cause;
    @(posedge busClk) disable iff (!busRst_n)
      $changed(reqTgl) |-> $past(convRead) && !$past(splitMode);
  endproperty
  a_req_cause: assert property (p_req_cause)
    else $error("core read request without a conventional read");

  property p_cov_delayed;
    @(posedge busClk) disable iff (!busRst_n)
      replyCode == RPL_DELAYED;
  endproperty
  c_cov_delayed: cover property (p_cov_delayed);

  property p_cov_disc;
    @(posedge busClk) disable iff (!busRst_n)
      replyCode == RPL_DISC_NEXT;
  endproperty
  c_cov_disc: cover property (p_cov_disc);

  property p_cov_pipe;
    @(posedge busClk) disable iff (!busRst_n)
      pipeEnq ##1 pipeEnq;
  endproperty
  c_cov_pipe: cover property (p_cov_pipe);

endmodule : iobtr_top
`default_nettype wire

// ---- dv/iobtr_card_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Bus master card model that presents one decoded cycle per call.
module iobtr_card_model (
  input wire logic busClk,
  output logic cycValid,
  output logic [63:0] cycAddr,
  output logic [3:0] cycCmd,
  output logic [2:0] cycMaster,
  output logic [5:0] cycFlags
);
  initial begin
    cycValid = 1'b0;
    cycAddr = 64'h0;
    cycCmd = 4'h0;
    cycMaster = 3'h0;
    cycFlags = 6'h00;
  end

  // Qualifiers are inverted after the pulse, so stale values can never match a slot.
  task automatic issue(input logic [3:0] c, input logic [63:0] a, input logic [2:0] m,
                       input logic [5:0] f);
    @(negedge busClk);
    cycValid = 1'b1;
    {cycCmd, cycAddr, cycMaster, cycFlags} = {c, a, m, f};
    @(negedge busClk);
    cycValid = 1'b0;
    {cycCmd, cycAddr, cycMaster, cycFlags} = ~{c, a, m, f};
  endtask : issue
endmodule : iobtr_card_model
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  import iobtr_pkg::*;
  logic core_clk = 1'b0, busClk = 1'b0, reset_n = 1'b0, busReset_n = 1'b0;
  logic relaxedMatch = 1'b0, splitCapStrap = 1'b0, agpStrap = 1'b0, phaseValid = 1'b0;
  logic [31:0] phaseAd = 32'h0;
  logic [3:0] phaseCbe = 4'h0, agpCmd = 4'h0, fenceCount, fc, k;
  logic phasePar = 1'b0, phaseRedundant = 1'b0, agpValid = 1'b0, dataParErr = 1'b0;
  logic ownReadSplitted = 1'b0, perrIn = 1'b0, splitCompAbort = 1'b0, dmaDataDone = 1'b0;
  logic claim, splitMode, agpMode, addrParErr, dataParErrSeen, perrSeen, serrOut, pipeEnq;
  logic dmaReadStart, cycValid, s, wf;
  logic [63:0] dmaReadAddr, cycAddr, a;
  logic [3:0] cycCmd;
  logic [2:0] cycMaster;
  logic [5:0] cycFlags, f;
  iobtr_reply_t replyCode;
  int seed = 22509, bad_count = 0, tests_run = 0, starts = 0, want = 0, i;
  logic [3:0] noClaim [6] = '{CMD_INT_ACK, CMD_SPECIAL, CMD_IO_RD, CMD_IO_WR, CMD_CFG_RD,
                              CMD_CFG_WR};

  // Core and bus clocks run at unrelated phases.
  always #2 core_clk = ~core_clk;
  initial #37 forever #80 busClk = ~busClk;
  // Read starts are pulses, so they are counted as they pass.
  always @(negedge core_clk) if (dmaReadStart === 1'b1) starts++;

  iobtr_card_model card (.busClk, .cycValid, .cycAddr, .cycCmd, .cycMaster, .cycFlags);
  iobtr_top uut (.core_clk, .reset_n, .busClk, .busReset_n, .relaxedMatch, .splitCapStrap,
    .agpStrap, .cycValid, .cycAddr, .cycCmd, .cycWide(cycFlags[5]), .cycPar(cycFlags[4]),
    .cycMaster, .cycOwnCompletion(cycFlags[3]), .cycSinglePhase(cycFlags[2]),
    .writeFull(cycFlags[1]), .splitFull(cycFlags[0]), .phaseValid, .phaseAd, .phaseCbe,
    .phasePar, .phaseRedundant, .agpValid, .agpCmd, .dataParErr, .ownReadSplitted, .perrIn,
    .splitCompAbort, .dmaDataDone, .claim, .replyCode, .splitMode, .agpMode, .addrParErr,
    .dataParErrSeen, .perrSeen, .serrOut, .pipeEnq, .fenceCount, .dmaReadStart, .dmaReadAddr);

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", n, exp, seen);
    end
  endtask : chk

  // One card cycle, then the answer is looked at after the reply edge.
  task automatic cyc(input logic [3:0] c, input logic [63:0] ad, input logic [2:0] m,
                     input logic [5:0] fl, input logic ec, input iobtr_reply_t er);
    card.issue(c, ad, m, fl);
    chk("claim", claim, ec);
    chk("replyCode", replyCode, er);
  endtask : cyc

  task automatic busRst(input logic sp, input logic ag);
    @(negedge busClk);
    busReset_n = 1'b0;
    {splitCapStrap, agpStrap} = {sp, ag};
    repeat (3) @(negedge busClk);
    busReset_n = 1'b1;
    repeat (8) @(negedge busClk);
    chk("splitMode", splitMode, sp & ~ag);
    chk("agpMode", agpMode, ag);
  endtask : busRst

  // Waits for the host fetch of the pending read and hands its data back.
  task automatic serve(input logic [63:0] ad);
    want++;
    for (int j = 0; j < 300 && starts < want; j++) @(negedge core_clk);
    chk("readStarts", 64'(starts), 64'(want));
    chk("dmaReadAddr", dmaReadAddr, ad);
    dmaDataDone = 1'b1;
    @(negedge core_clk);
    dmaDataDone = 1'b0;
    repeat (6) @(negedge busClk);
  endtask : serve

  function automatic iobtr_reply_t expWr(input logic [63:0] ad, input logic sg, input logic fu);
    if (fu) return RPL_RETRY;
    if (sg) return RPL_SINGLE_DISC;
    return (ad[6:0] != 7'h00) ? RPL_DISC_NEXT : RPL_DATA_XFER;
  endfunction : expWr

  initial begin
    #200000;
    bad_count++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1'b1;
    busRst(1'b0, 1'b0);
    a = {$random(seed), $random(seed)};
    f = {2'($random(seed)), 4'h0};
    cyc(CMD_MEM_RD, a, 3'h2, f, 1'b1, RPL_RETRY);
    serve(a);
    cyc(CMD_MEM_RD, a, 3'h5, f, 1'b1, RPL_RETRY);
    cyc(CMD_MULT_SPLIT, a, 3'h2, f, 1'b1, RPL_RETRY);
    cyc(CMD_MEM_RD, a ^ 64'h4, 3'h2, f, 1'b1, RPL_RETRY);
    cyc(CMD_MEM_RD, a, 3'h2, f ^ 6'h10, 1'b1, RPL_RETRY);
    cyc(CMD_MEM_RD, a, 3'h2, f, 1'b1, RPL_DELAYED);
    cyc(CMD_MEM_RD, a, 3'h2, f, 1'b1, RPL_RETRY);
    relaxedMatch = 1'b1;
    serve(a);
    cyc(CMD_LINE_BLKRD, a ^ 64'hFFFFF00000000003, 3'h2, f ^ 6'h20, 1'b1, RPL_DELAYED);
    cyc(CMD_MEM_WR, a, 3'h1, 6'h00, 1'b1, RPL_IMMEDIATE);
    cyc(CMD_INVAL_BLKWR, a, 3'h1, 6'h02, 1'b1, RPL_RETRY);
    cyc(CMD_DAC, a, 3'h1, 6'h00, 1'b1, RPL_NONE);
    foreach (noClaim[j]) cyc(noClaim[j], a, 3'h1, 6'h00, 1'b0, RPL_NONE);
    for (i = 0; i < 6; i++) begin
      @(negedge busClk);
      {phaseAd, phaseCbe, phasePar} = 37'({$random(seed), $random(seed)});
      phaseRedundant = i[0];
      phaseValid = 1'b1;
      @(negedge busClk);
      phaseValid = 1'b0;
      chk("addrParErr", addrParErr, ^{phaseAd, phaseCbe, phasePar} & ~phaseRedundant);
    end
    // Split-transaction mode after a fresh bus reset.
    busRst(1'b1, 1'b0);
    cyc(CMD_LINE_BLKRD, a, 3'h3, 6'h00, 1'b1, RPL_SPLIT);
    cyc(CMD_MEM_RD, a, 3'h3, 6'h01, 1'b1, RPL_RETRY);
    foreach (noClaim[j]) cyc(noClaim[j], a, 3'h1, 6'h00, 1'b0, RPL_NONE);
    cyc(CMD_DAC, a, 3'h1, 6'h00, 1'b0, RPL_NONE);
    for (i = 0; i < 8; i++) begin
      a = {$random(seed), $random(seed)};
      if (i < 2) a[6:0] = 7'h00;
      {s, wf} = 2'($random(seed));
      cyc(i[0] ? CMD_MEM_WR : CMD_INVAL_BLKWR, a, 3'h4, {3'h0, s, wf, 1'b0}, 1'b1,
          expWr(a, s, wf));
    end
    cyc(CMD_MULT_SPLIT, a, 3'h0, 6'h08, 1'b1, RPL_DATA_XFER);
    cyc(CMD_MULT_SPLIT, a, 3'h0, 6'h00, 1'b0, RPL_NONE);
    perrIn = 1'b1;
    cyc(CMD_MEM_RD, a, 3'h3, 6'h00, 1'b1, RPL_SPLIT);
    @(negedge busClk);
    chk("perrSeen", perrSeen, 1'b0);
    {perrIn, dataParErr, ownReadSplitted} = 3'b011;
    repeat (2) @(negedge busClk);
    chk("dataParErrSeen", dataParErrSeen, 1'b0);
    {ownReadSplitted, splitCompAbort} = 2'b01;
    repeat (2) @(negedge busClk);
    chk("dataParErrSeen", dataParErrSeen, 1'b1);
    chk("serrOut", serrOut, 1'b1);
    {dataParErr, splitCompAbort} = 2'b00;
    // Graphics port: every request code, fences only bump the ordering count.
    busRst(1'b0, 1'b1);
    fc = 4'h0;
    for (i = 0; i < 18; i++) begin
      k = 4'(i % 9);
      @(negedge busClk);
      {agpValid, agpCmd} = {1'b1, k};
      @(negedge busClk);
      agpValid = 1'b0;
      if (k == AGP_FENCE) fc++;
      chk("claim", claim, k != AGP_FENCE);
      chk("replyCode", replyCode, (k != AGP_FENCE) ? RPL_PIPE : RPL_NONE);
      chk("pipeEnq", pipeEnq, k != AGP_FENCE);
      chk("fenceCount", fenceCount, fc);
    end
    final_report();
  end
endmodule : tb
`default_nettype wire

// ---- shared/iobtr_match_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Carries a retried read and the stored slot contents to the comparator.
interface iobtr_match_if;
  logic [63:0] reqAddr;
  logic reqWide;
  logic [3:0] reqCmd;
  logic reqPar;
  logic [2:0] reqMaster;
  logic [63:0] slotAddr;
  logic slotWide;
  logic [3:0] slotCmd;
  logic slotPar;
  logic [2:0] slotMaster;
  logic relaxed;
  logic hit;
  modport slot (output reqAddr, reqWide, reqCmd, reqPar, reqMaster, slotAddr, slotWide,
                slotCmd, slotPar, slotMaster, relaxed, input hit);
  modport matcher (input reqAddr, reqWide, reqCmd, reqPar, reqMaster, slotAddr, slotWide,
                   slotCmd, slotPar, slotMaster, relaxed, output hit);
endinterface : iobtr_match_if
`default_nettype wire

// ---- shared/iobtr_pkg.sv ----
package iobtr_pkg;

  // ****************************************************************
  // Bus command encodings.
  // ****************************************************************
  localparam logic [3:0] CMD_INT_ACK = 4'h0;
  localparam logic [3:0] CMD_SPECIAL = 4'h1;
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  localparam logic [3:0] CMD_MULT_SPLIT = 4'hC;
  localparam logic [3:0] CMD_DAC = 4'hD;
  localparam logic [3:0] CMD_LINE_BLKRD = 4'hE;
  localparam logic [3:0] CMD_INVAL_BLKWR = 4'hF;

  // ****************************************************************
  // Graphics port request encodings.
  // ****************************************************************
  localparam logic [3:0] AGP_READ_LP = 4'h0;
  localparam logic [3:0] AGP_READ_HP = 4'h1;
  localparam logic [3:0] AGP_WRITE_LP = 4'h2;
  localparam logic [3:0] AGP_WRITE_HP = 4'h3;
  localparam logic [3:0] AGP_LONG_LP = 4'h4;
  localparam logic [3:0] AGP_LONG_HP = 4'h5;
  localparam logic [3:0] AGP_FLUSH = 4'h6;
  localparam logic [3:0] AGP_FENCE = 4'h7;
  localparam logic [3:0] AGP_DAC = 4'h8;

  // ****************************************************************
  // Field layout and counts.
  // ****************************************************************
  localparam int ADDR_W = 64;
  localparam int MID_W = 3;
  localparam int FENCE_W = 4;
  localparam logic [63:0] RELAX_MASK = 64'h00000FFFFFFFFFFC;
  localparam logic [6:0] BLOCK_OFFSET_ZERO = 7'h00;
  localparam int SYNC_STAGES = 3;

  typedef enum logic [3:0] {
    RPL_NONE, RPL_RETRY, RPL_SPLIT, RPL_DATA_XFER, RPL_DISC_NEXT,
    RPL_SINGLE_DISC, RPL_DELAYED, RPL_IMMEDIATE, RPL_PIPE
  } iobtr_reply_t;

  typedef enum logic [1:0] {SLOT_IDLE, SLOT_PENDING, SLOT_READY} iobtr_slot_t;

  // Conventional reads that go through the delayed completion slot.
  function automatic logic iobtrIsConvRead(input logic [3:0] cmd);
    iobtrIsConvRead = (cmd == CMD_MEM_RD) || (cmd == CMD_LINE_BLKRD) ||
                      (cmd == CMD_MULT_SPLIT);
  endfunction : iobtrIsConvRead

endpackage : iobtr_pkg
